// [design/serial_rx_framer_output.sv]
`timescale 1ns/100ps
// Behaviour
// - output byte holds until next byte
// - byte clock rises when outputs change
// - mode pin picks decoded, raw or test
// - raw mode maps symbol bits a..j
// - special flag marks control codes
// - violation flag marks code errors
// - self-test: violation low on matching byte
// - ready pulses low per byte, not Null
// - self-test: ready high only on last
// - select high picks input a
// - status output follows status input
// - reframe enable aligns to each sync, even-slot ones only in double mode
// - long reframe run enters double-byte mode
// - reframe low keeps counter framing
// - Null fill is the K28.5 symbol
// - self-test waits for D0.0, then runs
// - self-test compares against local LFSR
module serial_rx_framer_output (
   // clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        sys_rst_i,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             irq_o,
   // link side
   input  wire logic        serial_in_a_i,
   input  wire logic        serial_in_b_i,
   input  wire logic        in_sel_i,
   input  wire logic        status_in_i,
   input  wire logic [1:0]  mode_i,
   input  wire logic        reframe_enable_i,
   input  wire logic        self_test_enable_n_i,
   // host side
   output logic      [7:0]  rx_byte_out_o,
   output logic             special_char_flag_o,
   output logic             violation_flag_o,
   output logic             ready_n_o,
   output logic             recovered_byte_clock_o,
   output logic             status_out_o
);

   logic [9:0]  sh, next_sh, nsh;
   logic [3:0]  bitcnt, next_bitcnt;
   logic [11:0] run, next_run;
   logic        par, next_par, dbl, next_dbl, b_prev;
   logic        test_mode, bit_en, bit_in, realign, byte_ev;
   logic [7:0]  dec_data;
   logic        dec_k, dec_err, is_null, is_start;
   rx_framer_pkg::sym_t cap, out, next_out;
   logic        next_rdy_n, next_bclk;
   rx_framer_pkg::bist_st_t bst, next_bst;
   logic [8:0]  lfsr, next_lfsr;
   logic        bist_match, bist_last;
   logic [rx_framer_pkg::IRQ_W-1:0] ist, next_ist, imask, next_imask, ev;
   logic [rx_framer_pkg::IRQ_W-1:0] clr;
   logic        wb_hit, wb_wr, next_irq;
   logic [31:0] rd, next_dat;

   function automatic logic is_comma(input logic [9:0] s);
      logic [6:0] a2g;
      a2g      = {s[0], s[1], s[2], s[3], s[4], s[5], s[6]};
      is_comma = (a2g == rx_framer_pkg::COMMA_NEG) ||
                 (a2g == rx_framer_pkg::COMMA_POS);
   endfunction : is_comma

   // x^9 + x^5 + 1, 511 states per loop
   function automatic logic [8:0] lfsr_step(input logic [8:0] l);
      lfsr_step = {l[7:0], l[8] ^ l[4]};
   endfunction : lfsr_step

   dec_8b10b u_dec (
      .sym_i  (nsh),
      .data_o (dec_data),
      .k_o    (dec_k),
      .err_o  (dec_err)
   );

   // framer
   always_comb begin
      test_mode = (mode_i == rx_framer_pkg::MODE_TEST);
      bit_en    = test_mode ? (serial_in_b_i & ~b_prev) : 1'b1;
      bit_in    = (test_mode | in_sel_i) ? serial_in_a_i : serial_in_b_i;
      nsh       = {bit_in, sh[9:1]};
      // sync realigns; even slot only in double mode
      realign   = bit_en & reframe_enable_i & is_comma(nsh) & (~dbl | ~par);
      // counter boundary otherwise
      // a sync while the byte clock is high only restarts the count, so
      // the clock stretches rather than data changing off its rising edge
      byte_ev   = bit_en & ((bitcnt == rx_framer_pkg::BITS_LAST) |
                            (realign & ~recovered_byte_clock_o));
      next_sh   = bit_en ? nsh : sh;
      next_bitcnt = bitcnt;
      if (byte_ev | realign) begin
         next_bitcnt = 4'h0;
      end else if (bit_en) begin
         next_bitcnt = 4'(bitcnt + 4'h1);
      end
      next_par = byte_ev ? ~par : par;
      // count bytes while reframe stays high
      next_run = run;
      if (!reframe_enable_i) begin
         next_run = 12'h000;
      end else if (byte_ev && run != rx_framer_pkg::RUN_BYTES) begin
         next_run = 12'(run + 12'h001);
      end
      // leave double mode when reframe drops
      next_dbl = reframe_enable_i &
                 (dbl | (next_run == rx_framer_pkg::RUN_BYTES));
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         sh     <= 10'h000;
         bitcnt <= 4'h0;
         run    <= 12'h000;
         par    <= 1'b0;
         dbl    <= 1'b0;
         b_prev <= 1'b0;
      end else begin
         sh     <= next_sh;
         bitcnt <= next_bitcnt;
         run    <= next_run;
         par    <= next_par;
         dbl    <= next_dbl;
         b_prev <= serial_in_b_i;
      end
   end

   // self-test checker
   always_comb begin
      is_null    = dec_k & ~dec_err & (dec_data == rx_framer_pkg::NULL_BYTE);
      is_start   = ~dec_k & ~dec_err & (dec_data == rx_framer_pkg::START_BYTE);
      bist_match = ~dec_err & ({dec_k, dec_data} == lfsr);
      bist_last  = (lfsr_step(lfsr) == rx_framer_pkg::LFSR_SEED);
      next_bst   = bst;
      next_lfsr  = lfsr;
      case (bst)
         rx_framer_pkg::B_IDLE: begin
            if (!self_test_enable_n_i) next_bst = rx_framer_pkg::B_WAIT;
         end
         rx_framer_pkg::B_WAIT: begin
            if (self_test_enable_n_i) begin
               next_bst = rx_framer_pkg::B_IDLE;
            end else if (byte_ev && is_start) begin
               next_bst  = rx_framer_pkg::B_RUN;
               next_lfsr = rx_framer_pkg::LFSR_SEED;
            end
         end
         default: begin
            if (self_test_enable_n_i) begin
               next_bst = rx_framer_pkg::B_IDLE;
            end else if (byte_ev) begin
               next_lfsr = lfsr_step(lfsr);
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         bst  <= rx_framer_pkg::B_IDLE;
         lfsr <= rx_framer_pkg::LFSR_SEED;
      end else begin
         bst  <= next_bst;
         lfsr <= next_lfsr;
      end
   end

   // host outputs
   always_comb begin
      cap = '{special: dec_k, data: dec_data, viol: dec_err};
      if (mode_i == rx_framer_pkg::MODE_RAW) begin
         cap = '{special: nsh[0], data: nsh[8:1], viol: nsh[9]};
      end
      next_out   = out;
      next_rdy_n = ready_n_o;
      next_bclk  = (next_bitcnt < rx_framer_pkg::BITS_HALF);
      // load only on a new byte
      if (byte_ev) begin
         next_out = cap;
         if (bst == rx_framer_pkg::B_RUN) begin
            next_out.viol = ~bist_match;
            next_rdy_n    = bist_last;
         end else begin
            next_rdy_n = is_null;
         end
      end else if (bit_en && next_bitcnt == rx_framer_pkg::BITS_HALF &&
                   bst != rx_framer_pkg::B_RUN) begin
         next_rdy_n = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         out                    <= '{special: 1'b0,
                                     data: rx_framer_pkg::BYTE_RST,
                                     viol: 1'b0};
         ready_n_o              <= 1'b1;
         recovered_byte_clock_o <= 1'b0;
         status_out_o           <= 1'b0;
      end else begin
         out                    <= next_out;
         ready_n_o              <= next_rdy_n;
         recovered_byte_clock_o <= next_bclk;
         status_out_o           <= status_in_i;
      end
   end

   assign rx_byte_out_o       = out.data;
   assign special_char_flag_o = out.special;
   assign violation_flag_o    = out.viol;

   // wishbone slave and interrupts; write lands when ack is seen
   always_comb begin
      wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_wr  = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
      ev     = '0;
      ev[rx_framer_pkg::IRQ_NEW]  = byte_ev & ~is_null;
      ev[rx_framer_pkg::IRQ_VIOL] = byte_ev & next_out.viol;
      ev[rx_framer_pkg::IRQ_SYNC] = realign;
      ev[rx_framer_pkg::IRQ_LOOP] = byte_ev & bist_last &
                                    (bst == rx_framer_pkg::B_RUN);
      clr        = '0;
      next_imask = imask;
      if (wb_wr && wb_adr_i == rx_framer_pkg::ADDR_IRQ_STAT) begin
         clr = wb_dat_i[rx_framer_pkg::IRQ_W-1:0];
      end else if (wb_wr && wb_adr_i == rx_framer_pkg::ADDR_IRQ_MASK) begin
         next_imask = wb_dat_i[rx_framer_pkg::IRQ_W-1:0];
      end
      // an event in the clearing cycle survives
      next_ist = (ist & ~clr) | ev;
      next_irq = |(next_ist & next_imask);
      rd = 32'h0000_0000;
      if (wb_adr_i == rx_framer_pkg::ADDR_STATUS) begin
         rd[rx_framer_pkg::STAT_DBL]  = dbl;
         rd[rx_framer_pkg::STAT_WAIT] = (bst == rx_framer_pkg::B_WAIT);
         rd[rx_framer_pkg::STAT_RUN]  = (bst == rx_framer_pkg::B_RUN);
         rd[rx_framer_pkg::STAT_MON]  = status_out_o;
         rd[rx_framer_pkg::STAT_SYM_LSB +: 10] = out;
      end else if (wb_adr_i == rx_framer_pkg::ADDR_IRQ_STAT) begin
         rd[rx_framer_pkg::IRQ_W-1:0] = ist;
      end else if (wb_adr_i == rx_framer_pkg::ADDR_IRQ_MASK) begin
         rd[rx_framer_pkg::IRQ_W-1:0] = imask;
      end
      next_dat = wb_hit ? rd : 32'h0000_0000;
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         ist      <= '0;
         imask    <= rx_framer_pkg::IRQ_MASK_RST;
         irq_o    <= 1'b0;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         ist      <= next_ist;
         imask    <= next_imask;
         irq_o    <= next_irq;
         wb_ack_o <= wb_hit;
         wb_dat_o <= next_dat;
      end
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);

   property p_hold;
      !byte_ev |=> $stable(rx_byte_out_o) && $stable(violation_flag_o);
   endproperty
   a_hold: assert property (p_hold) else $error("byte changed");
   property p_clk;
      $changed(rx_byte_out_o) |-> recovered_byte_clock_o && !$past(next_bclk, 2);
   endproperty
   a_clk: assert property (p_clk) else $error("data off clock");
   property p_test;
      test_mode && !(serial_in_b_i && !b_prev) |=> $stable(sh);
   endproperty
   a_test: assert property (p_test) else $error("bit without clock");
   property p_raw;
      byte_ev && mode_i == rx_framer_pkg::MODE_RAW && bst != rx_framer_pkg::B_RUN
      |=> rx_byte_out_o == $past(nsh[8:1]) && special_char_flag_o == $past(nsh[0])
          && violation_flag_o == $past(nsh[9]);
   endproperty
   a_raw: assert property (p_raw) else $error("raw map wrong");
   property p_dec;
      byte_ev && mode_i == rx_framer_pkg::MODE_DECODED && bst != rx_framer_pkg::B_RUN
      |=> special_char_flag_o == $past(dec_k) && violation_flag_o == $past(dec_err);
   endproperty
   a_dec: assert property (p_dec) else $error("flags wrong");
   property p_bviol;
      byte_ev && bst == rx_framer_pkg::B_RUN |=> violation_flag_o == !$past(bist_match);
   endproperty
   a_bviol: assert property (p_bviol) else $error("test check wrong");
   property p_rdy;
      byte_ev && bst != rx_framer_pkg::B_RUN |=> ready_n_o == $past(is_null);
   endproperty
   a_rdy: assert property (p_rdy) else $error("ready pulse wrong");
   property p_brdy;
      byte_ev && bst == rx_framer_pkg::B_RUN |=> ready_n_o == $past(bist_last);
   endproperty
   a_brdy: assert property (p_brdy) else $error("test ready wrong");
   property p_sel;
      !test_mode |=> sh[9] == ($past(in_sel_i) ? $past(serial_in_a_i)
                                              : $past(serial_in_b_i));
   endproperty
   a_sel: assert property (p_sel) else $error("input select wrong");
   property p_mon;
      status_in_i |=> status_out_o;
   endproperty
   a_mon: assert property (p_mon) else $error("status not followed");
   property p_align;
      realign |=> bitcnt == 4'h0 ##1 (bitcnt <= 4'h1);
   endproperty
   a_align: assert property (p_align) else $error("no realign");
   property p_dbl;
      run == rx_framer_pkg::RUN_BYTES |-> dbl;
   endproperty
   a_dbl: assert property (p_dbl) else $error("double mode missed");
   property p_noalign;
      !reframe_enable_i && bit_en && bitcnt != rx_framer_pkg::BITS_LAST
      |=> bitcnt == 4'($past(bitcnt) + 4'h1);
   endproperty
   a_noalign: assert property (p_noalign) else $error("framing moved");
   property p_start;
      bst == rx_framer_pkg::B_WAIT && byte_ev && is_start && !self_test_enable_n_i
      |=> bst == rx_framer_pkg::B_RUN && lfsr == rx_framer_pkg::LFSR_SEED;
   endproperty
   a_start: assert property (p_start) else $error("test start missed");
   property p_lfsr;
      bst == rx_framer_pkg::B_RUN && byte_ev && !self_test_enable_n_i
      |=> lfsr == lfsr_step($past(lfsr));
   endproperty
   a_lfsr: assert property (p_lfsr) else $error("sequence stalled");
   property p_dexit;
      !reframe_enable_i |=> !dbl && run == 12'h000;
   endproperty
   a_dexit: assert property (p_dexit) else $error("double mode kept");

   c_realign: cover property (realign);
   c_dbl:     cover property (dbl && realign);
   c_loop:    cover property (ev[rx_framer_pkg::IRQ_LOOP]);
   c_null:    cover property (byte_ev && is_null);

endmodule : serial_rx_framer_output

// [design/rx_framer_pkg.sv]
package rx_framer_pkg;

   // register byte addresses on the bus
   localparam logic [7:0] ADDR_STATUS   = 8'h00;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h04;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;

   // status register fields
   localparam int STAT_DBL     = 0;
   localparam int STAT_WAIT    = 1;
   localparam int STAT_RUN     = 2;
   localparam int STAT_MON     = 3;
   localparam int STAT_SYM_LSB = 4;

   // interrupt bits, same layout in status and mask
   localparam int IRQ_W    = 4;
   localparam int IRQ_NEW  = 0;
   localparam int IRQ_VIOL = 1;
   localparam int IRQ_SYNC = 2;
   localparam int IRQ_LOOP = 3;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

   // three-level mode pin, low, floating and high
   localparam logic [1:0] MODE_DECODED = 2'h0;
   localparam logic [1:0] MODE_TEST    = 2'h1;
   localparam logic [1:0] MODE_RAW     = 2'h3;

   // bit counts within one symbol
   localparam logic [3:0] BITS_LAST = 4'h9;
   localparam logic [3:0] BITS_HALF = 4'h5;

   // framer run length before double-byte mode
   localparam logic [11:0] RUN_BYTES = 12'h800;

   // symbol constants
   localparam logic [6:0] COMMA_NEG  = 7'h1F;
   localparam logic [6:0] COMMA_POS  = 7'h60;
   localparam logic [7:0] NULL_BYTE  = 8'hBC;
   localparam logic [7:0] START_BYTE = 8'h00;
   localparam logic [8:0] LFSR_SEED  = 9'h1FF;

   // reset values of the host outputs
   localparam logic [7:0] BYTE_RST = 8'h00;

   typedef enum logic [1:0] {B_IDLE, B_WAIT, B_RUN} bist_st_t;

   typedef struct packed {
      logic       special;
      logic [7:0] data;
      logic       viol;
   } sym_t;

endpackage : rx_framer_pkg

// [design/dec_8b10b.sv]
`timescale 1ns/100ps
module dec_8b10b (
   // symbol, bit a in bit 0
   input  wire logic [9:0] sym_i,
   // decoded byte
   output logic       [7:0] data_o,
   output logic             k_o,
   output logic             err_o
);

   logic [5:0] c6;
   logic [3:0] c4;
   logic [6:0] r6;
   logic [4:0] r4;

   // returns {valid, k28, x}
   function automatic logic [6:0] dec6(input logic [5:0] c);
      case (c)
         6'h27, 6'h18: dec6 = {2'h2, 5'h00};
         6'h1D, 6'h22: dec6 = {2'h2, 5'h01};
         6'h2D, 6'h12: dec6 = {2'h2, 5'h02};
         6'h31:        dec6 = {2'h2, 5'h03};
         6'h35, 6'h0A: dec6 = {2'h2, 5'h04};
         6'h29:        dec6 = {2'h2, 5'h05};
         6'h19:        dec6 = {2'h2, 5'h06};
         6'h38, 6'h07: dec6 = {2'h2, 5'h07};
         6'h39, 6'h06: dec6 = {2'h2, 5'h08};
         6'h25:        dec6 = {2'h2, 5'h09};
         6'h15:        dec6 = {2'h2, 5'h0A};
         6'h34:        dec6 = {2'h2, 5'h0B};
         6'h0D:        dec6 = {2'h2, 5'h0C};
         6'h2C:        dec6 = {2'h2, 5'h0D};
         6'h1C:        dec6 = {2'h2, 5'h0E};
         6'h17, 6'h28: dec6 = {2'h2, 5'h0F};
         6'h1B, 6'h24: dec6 = {2'h2, 5'h10};
         6'h23:        dec6 = {2'h2, 5'h11};
         6'h13:        dec6 = {2'h2, 5'h12};
         6'h32:        dec6 = {2'h2, 5'h13};
         6'h0B:        dec6 = {2'h2, 5'h14};
         6'h2A:        dec6 = {2'h2, 5'h15};
         6'h1A:        dec6 = {2'h2, 5'h16};
         6'h3A, 6'h05: dec6 = {2'h2, 5'h17};
         6'h33, 6'h0C: dec6 = {2'h2, 5'h18};
         6'h26:        dec6 = {2'h2, 5'h19};
         6'h16:        dec6 = {2'h2, 5'h1A};
         6'h36, 6'h09: dec6 = {2'h2, 5'h1B};
         6'h0E:        dec6 = {2'h2, 5'h1C};
         6'h2E, 6'h11: dec6 = {2'h2, 5'h1D};
         6'h1E, 6'h21: dec6 = {2'h2, 5'h1E};
         6'h2B, 6'h14: dec6 = {2'h2, 5'h1F};
         6'h0F, 6'h30: dec6 = {2'h3, 5'h1C};
         default:      dec6 = 7'h00;
      endcase
   endfunction : dec6

   // returns {valid, alternate seven, y}
   function automatic logic [4:0] dec4(input logic [3:0] c);
      case (c)
         4'hB, 4'h4: dec4 = 5'h10;
         4'h9:       dec4 = 5'h11;
         4'h5:       dec4 = 5'h12;
         4'hC, 4'h3: dec4 = 5'h13;
         4'hD, 4'h2: dec4 = 5'h14;
         4'hA:       dec4 = 5'h15;
         4'h6:       dec4 = 5'h16;
         4'hE, 4'h1: dec4 = 5'h17;
         4'h7, 4'h8: dec4 = 5'h1F;
         default:    dec4 = 5'h00;
      endcase
   endfunction : dec4

   // no running disparity is tracked, only invalid sub-blocks flag
   always_comb begin
      c6     = {sym_i[0], sym_i[1], sym_i[2], sym_i[3], sym_i[4], sym_i[5]};
      // k28 sub-blocks after the positive six-bit code come complemented
      c4     = {sym_i[6], sym_i[7], sym_i[8], sym_i[9]} ^ {4{c6 == 6'h30}};
      r6     = dec6(c6);
      r4     = dec4(c4);
      data_o = {r4[2:0], r6[4:0]};
      k_o    = r6[5] | (r4[3] & (r6[4:0] == 5'h17 || r6[4:0] == 5'h1B ||
                                 r6[4:0] == 5'h1D || r6[4:0] == 5'h1E));
      err_o  = ~r6[6] | ~r4[4];
   end

endmodule : dec_8b10b

// [sim/serial_tx_model.sv]
`timescale 1ns/100ps
module serial_tx_model (
   // clock
   input  wire logic sys_clk_i,
   // serial line, bit a first
   output logic      line_o
);
   localparam logic [9:0] FILL = 10'h17C;
   logic bits_q[$];

   task automatic put(input logic [9:0] sym, input int n);
      for (int i = 0; i < n; i++) begin
         bits_q.push_back(sym[i]);
      end
   endtask : put

   // refill only when empty, so queued symbols start on a frame
   always @(posedge sys_clk_i) begin
      if (bits_q.size() == 0) begin
         put(FILL, 10);
      end
      line_o <= bits_q.pop_front();
   end

endmodule : serial_tx_model

// [sim/serial_rx_framer_output_bench.sv]
`timescale 1ns/100ps
module serial_rx_framer_output_bench;
   logic        sys_clk_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
   logic [3:0]  wb_sel_i = 4'hF;
   logic        wb_ack_o, irq_o, line, serial_in_a_i, serial_in_b_i;
   logic        in_sel_i = 1'b1, status_in_i = 1'b0, reframe_enable_i = 1'b0;
   logic        self_test_enable_n_i = 1'b1;
   logic [1:0]  mode_i = 2'h3;
   logic [7:0]  rx_byte_out_o;
   logic        special_char_flag_o, violation_flag_o, ready_n_o;
   logic        recovered_byte_clock_o, status_out_o;
   int          fails = 0, checked = 0, hi = 0, nulls = 0, n = 0;
   logic        bclk_q = 1'b0, st_q = 1'b0, rst_q = 1'b1, chk_en = 1'b0;
   logic        tclk = 1'b0;
   logic        vonly_q[$];
   logic [9:0]  s;
   rx_framer_pkg::sym_t got, null_s, exp_q[$];

   always #25 sys_clk_i = ~sys_clk_i;
   // unselected input carries the inverse, never a copy; b clocks test mode
   assign serial_in_a_i = in_sel_i ? line : ~line;
   assign serial_in_b_i = (mode_i == rx_framer_pkg::MODE_TEST) ? tclk :
                          (in_sel_i ? ~line : line);

   serial_tx_model tx_i (.sys_clk_i(sys_clk_i), .line_o(line));
   serial_rx_framer_output serial_rx_framer_output_i (
      .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .irq_o(irq_o), .serial_in_a_i(serial_in_a_i),
      .serial_in_b_i(serial_in_b_i), .in_sel_i(in_sel_i),
      .status_in_i(status_in_i), .mode_i(mode_i),
      .reframe_enable_i(reframe_enable_i),
      .self_test_enable_n_i(self_test_enable_n_i),
      .rx_byte_out_o(rx_byte_out_o), .special_char_flag_o(special_char_flag_o),
      .violation_flag_o(violation_flag_o), .ready_n_o(ready_n_o),
      .recovered_byte_clock_o(recovered_byte_clock_o),
      .status_out_o(status_out_o));

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      checked++;
      if (seen !== want) begin
         fails++;
         $display("ERROR %0t seen %h want %h", $time, seen, want);
      end
   endtask : check

   task automatic close_out();
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : close_out

   task automatic wb(input logic we, input logic [7:0] adr, input int dat);
      int n = 0;
      @(posedge sys_clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      rd = wb_dat_o;
      check({31'h0, wb_ack_o}, 32'h1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask : wb

   function automatic logic [9:0] raw(input logic [9:0] v);
      return {v[0], v[8:1], v[9]};
   endfunction : raw

   // comma-like and null-like symbols would alias the fill
   function automatic logic [9:0] rnd_sym();
      logic [9:0] v;
      do v = 10'($urandom);
      while (v[6:0] == 7'h7C || v[6:0] == 7'h03 || v[8:1] == 8'hBC);
      return v;
   endfunction : rnd_sym

   task automatic send(input logic [9:0] v, input logic [9:0] e,
                       input logic vo);
      tx_i.put(v, 10);
      exp_q.push_back(e);
      vonly_q.push_back(vo);
   endtask : send

   task automatic drain(input int cnt);
      int n = 0;
      for (int i = 0; i < cnt; i++) begin
         s = rnd_sym();
         send(s, raw(s), 1'b0);
      end
      while (exp_q.size() != 0 && n < 900) begin
         @(posedge sys_clk_i);
         n++;
      end
      check(exp_q.size(), 0);
   endtask : drain

   task automatic realign();
      reframe_enable_i <= 1'b1;
      repeat (80) @(posedge sys_clk_i);
      reframe_enable_i <= 1'b0;
      @(posedge recovered_byte_clock_o);
      chk_en = 1'b1;
   endtask : realign

   task automatic restart(input logic [1:0] m, input logic sel,
                          input logic [9:0] nul);
      chk_en = 1'b0;
      null_s = nul;
      @(posedge sys_clk_i);
      sys_rst_i <= 1'b1;
      mode_i <= m;
      in_sel_i <= sel;
      repeat (6) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      realign();
   endtask : restart

   always @(posedge sys_clk_i) begin
      bclk_q <= recovered_byte_clock_o;
      st_q <= status_in_i;
      rst_q <= sys_rst_i;
      status_in_i <= 1'($urandom);
      tclk <= ~tclk;
      if (!sys_rst_i && !rst_q) check(status_out_o, st_q);
      if (recovered_byte_clock_o && !bclk_q) begin
         got = {special_char_flag_o, rx_byte_out_o, violation_flag_o};
         if (got === null_s) nulls++;
         if (chk_en && got === null_s) check(ready_n_o, 1);
         else if (chk_en) begin
            check(ready_n_o, 0);
            if (exp_q.size() == 0) check(got, null_s);
            else if (vonly_q[0]) check(got.viol, 1);
            else check(got, exp_q[0]);
            if (exp_q.size() != 0) exp_q.delete(0);
            if (vonly_q.size() != 0) vonly_q.delete(0);
         end
      end else if (chk_en) begin
         check({special_char_flag_o, rx_byte_out_o, violation_flag_o},
               got);
      end
      if (recovered_byte_clock_o) hi++;
      else begin
         if (bclk_q && chk_en) check(hi, 5);
         if (bclk_q && chk_en) check(ready_n_o, 1);
         hi = 0;
      end
   end

   initial begin
      repeat (60000) @(posedge sys_clk_i);
      fails++;
      close_out();
   end

   initial begin
      void'($urandom(32'h5113));
      restart(rx_framer_pkg::MODE_RAW, 1'b1, raw(10'h17C));
      drain(12);
      chk_en = 1'b0;
      tx_i.put(10'h005, 3);
      repeat (30) @(posedge sys_clk_i);
      nulls = 0;
      repeat (60) @(posedge sys_clk_i);
      check(nulls, 0);
      realign();
      check(nulls != 0, 1);
      drain(6);
      wb(1'b1, rx_framer_pkg::ADDR_IRQ_STAT, 32'hF);
      wb(1'b0, rx_framer_pkg::ADDR_IRQ_STAT, 0);
      check(rd[rx_framer_pkg::IRQ_NEW], 0);
      wb(1'b1, rx_framer_pkg::ADDR_IRQ_MASK, 1);
      wb(1'b0, rx_framer_pkg::ADDR_IRQ_MASK, 0);
      check(rd, 32'h1);
      check(irq_o, 0);
      drain(1);
      repeat (3) @(posedge sys_clk_i);
      check(irq_o, 1);
      wb(1'b1, rx_framer_pkg::ADDR_IRQ_STAT, 1);
      repeat (3) @(posedge sys_clk_i);
      check(irq_o, 0);
      wb(1'b0, 8'h0C, 0);
      check(rd, 0);
      reframe_enable_i <= 1'b1;
      repeat (20000) @(posedge sys_clk_i);
      wb(1'b0, rx_framer_pkg::ADDR_STATUS, 0);
      check(rd[rx_framer_pkg::STAT_DBL], 0);
      repeat (800) @(posedge sys_clk_i);
      wb(1'b0, rx_framer_pkg::ADDR_STATUS, 0);
      check(rd[rx_framer_pkg::STAT_DBL], 1);
      reframe_enable_i <= 1'b0;
      wb(1'b0, rx_framer_pkg::ADDR_STATUS, 0);
      check(rd[rx_framer_pkg::STAT_DBL], 0);
      // mid level: input b becomes the bit clock, two cycles a bit
      chk_en = 1'b0;
      mode_i <= rx_framer_pkg::MODE_TEST;
      repeat (2) @(posedge recovered_byte_clock_o);
      repeat (7) @(posedge sys_clk_i);
      check(recovered_byte_clock_o, 1);
      restart(rx_framer_pkg::MODE_DECODED, 1'b0, 10'h378);
      send(10'h0B9, 10'h000, 1'b0);
      send(10'h155, 10'h16A, 1'b0);
      send(10'h000, 10'h001, 1'b1);
      send(10'h155, 10'h16A, 1'b0);
      drain(0);
      // self-test: D0.0 opens it, the fill misses, K30.7 is the second code
      chk_en = 1'b0;
      self_test_enable_n_i <= 1'b0;
      wb(1'b0, rx_framer_pkg::ADDR_STATUS, 0);
      check(rd[rx_framer_pkg::STAT_WAIT], 1);
      tx_i.put(10'h0B9, 10);
      tx_i.put(10'h17C, 10);
      tx_i.put(10'h05E, 10);
      while (rx_byte_out_o !== 8'hFE && n < 100) begin
         @(posedge sys_clk_i);
         n++;
      end
      check(rx_byte_out_o, 8'hFE);
      check(violation_flag_o, 0);
      check(ready_n_o, 0);
      wb(1'b0, rx_framer_pkg::ADDR_STATUS, 0);
      check(rd[rx_framer_pkg::STAT_RUN], 1);
      close_out();
   end
endmodule : serial_rx_framer_output_bench
